/* nv_store_pkg.sv */
package nv_store_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register offsets inside the I/O window
	localparam logic [5:0] OFS_CONTROL = 6'h1F;
	localparam logic [5:0] OFS_DATA = 6'h20;
	localparam logic [5:0] OFS_ADDR_LOW = 6'h21;
	localparam logic [5:0] OFS_ADDR_HIGH = 6'h22;
	localparam logic [5:0] OFS_IRQ_STATUS = 6'h23;
	localparam logic [5:0] OFS_IRQ_ENABLE = 6'h24;
	localparam logic [5:0] OFS_IRQ_CLEAR = 6'h25;

	////////////////////////////////////////////////////////////////////////////
	// Control register field positions
	localparam int CTL_READ_STROBE_BIT = 0;
	localparam int CTL_START_BIT = 1;
	localparam int CTL_ARM_BIT = 2;
	localparam int CTL_MODE_LO_BIT = 4;
	localparam int CTL_MODE_HI_BIT = 5;

	////////////////////////////////////////////////////////////////////////////
	// Interrupt status bit positions
	localparam int IRQ_PROG_DONE_BIT = 0;
	localparam int IRQ_READ_DONE_BIT = 1;
	localparam int IRQ_REFUSED_BIT = 2;
	localparam int IRQ_W = 3;

	////////////////////////////////////////////////////////////////////////////
	// Store geometry and programming modes
	localparam int NV_ADDR_W = 9;
	localparam int NV_DATA_W = 8;
	localparam int NV_DEPTH = 512;
	localparam logic [1:0] MODE_ERASE_WRITE = 2'h0;
	localparam logic [1:0] MODE_ERASE_ONLY = 2'h1;
	localparam logic [1:0] MODE_WRITE_ONLY = 2'h2;
	localparam logic [1:0] MODE_RESET = 2'h0;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;

	////////////////////////////////////////////////////////////////////////////
	// Cycle counts
	localparam logic [2:0] READ_STALL_CYCLES = 3'h4;
	localparam logic [2:0] PROG_STALL_CYCLES = 3'h2;
	localparam logic [2:0] ARM_WINDOW_CYCLES = 3'h4;

endpackage

/* byte_eeprom_access_controller.sv */
// Our own choices: the address map and the address-and-strobe port.
module byte_eeprom_access_controller
	import nv_store_pkg::*;
#(
	parameter int TICK_W = 16,
	parameter logic [TICK_W-1:0] ERASE_WRITE_TICKS = 16'h0064,
	parameter logic [TICK_W-1:0] ERASE_ONLY_TICKS = 16'h0032,
	parameter logic [TICK_W-1:0] WRITE_ONLY_TICKS = 16'h0032
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [5:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	input wire logic osc_tick_in,
	output logic [7:0] rdata_out,
	output logic cpu_stall_out,
	output logic busy_out,
	output logic irq_out
);

	////////////////////////////////////////////////////////////////////////////
	// State types

	// Programming sequencer
	typedef enum logic {
		ST_IDLE,
		ST_PROG
	} prog_state_t;

	// All registers of the block except the cell array
	typedef struct packed {
		logic [1:0] mode;                 // Programming mode field
		logic [2:0] arm_cnt;              // Cycles left in arm window
		prog_state_t state;               // Sequencer state
		logic [1:0] op;                   // Mode latched at launch
		logic [NV_ADDR_W-1:0] prog_addr;  // Address latched at launch
		logic [NV_DATA_W-1:0] prog_data;  // Data latched at launch
		logic [TICK_W-1:0] tick_cnt;      // Oscillator ticks elapsed
		logic [NV_ADDR_W-1:0] addr;       // Byte address register
		logic [NV_DATA_W-1:0] data;       // Byte data register
		logic [2:0] stall_cnt;            // CPU stall cycles left
		logic stall;                      // Registered stall output
		logic [IRQ_W-1:0] irq_status;     // Sticky event bits
		logic [IRQ_W-1:0] irq_enable;     // Event enables
		logic irq;                        // Registered interrupt line
		logic [7:0] rdata;                // Read data, one cycle late
	} state_t;

	////////////////////////////////////////////////////////////////////////////
	// Storage

	state_t cur_ff;                            // Registered state
	state_t nxt_cur;                           // Next state
	logic [NV_DATA_W-1:0] cells [NV_DEPTH];    // Nonvolatile cells
	logic cell_we;                             // Commit programming result
	logic [NV_DATA_W-1:0] cell_wdata;          // Value committed to the cell

	////////////////////////////////////////////////////////////////////////////
	// Decode helpers

	logic wr_ctl;          // Write to control register
	logic wr_data;         // Write to data register
	logic wr_alow;         // Write to address low register
	logic wr_ahigh;        // Write to address high register
	logic wr_ien;          // Write to interrupt enable
	logic wr_iclr;         // Write to interrupt clear
	logic busy;            // Programming in progress
	logic armed;           // Arm window open
	logic launch;          // Programming starts this cycle
	logic read_go;         // Read fetch this cycle
	logic refused;         // Request refused because busy
	logic prog_done;       // Programming completes this cycle
	logic [TICK_W-1:0] tick_target; // Ticks needed for latched mode
	logic [IRQ_W-1:0] irq_set;      // Events raised this cycle

	// Address decode of one-cycle strobes
	always_comb begin
		wr_ctl = wr_en_in && (addr_in == OFS_CONTROL);
		wr_data = wr_en_in && (addr_in == OFS_DATA);
		wr_alow = wr_en_in && (addr_in == OFS_ADDR_LOW);
		wr_ahigh = wr_en_in && (addr_in == OFS_ADDR_HIGH);
		wr_ien = wr_en_in && (addr_in == OFS_IRQ_ENABLE);
		wr_iclr = wr_en_in && (addr_in == OFS_IRQ_CLEAR);
	end

	// Operation control decisions
	always_comb begin
		busy = (cur_ff.state == ST_PROG);
		armed = (cur_ff.arm_cnt != 3'h0);
		// Reserved mode 3 launches nothing, rather than guessing a cell effect
		launch = wr_ctl && wdata_in[CTL_START_BIT] && armed && !busy
			&& (cur_ff.mode != 2'h3);
		read_go = wr_ctl && wdata_in[CTL_READ_STROBE_BIT] && !busy;
		refused = wr_ctl && busy
			&& (wdata_in[CTL_READ_STROBE_BIT] || wdata_in[CTL_ARM_BIT]);
		case (cur_ff.op)
			MODE_ERASE_WRITE: tick_target = ERASE_WRITE_TICKS;
			MODE_ERASE_ONLY: tick_target = ERASE_ONLY_TICKS;
			MODE_WRITE_ONLY: tick_target = WRITE_ONLY_TICKS;
			default: tick_target = ERASE_WRITE_TICKS;
		endcase
		// Duration is paced by the calibrated oscillator only
		prog_done = busy && osc_tick_in
			&& (cur_ff.tick_cnt + 16'h0001 >= tick_target);
	end

	// Cell result for the latched mode
	always_comb begin
		cell_we = prog_done;
		case (cur_ff.op)
			MODE_ERASE_WRITE: cell_wdata = cur_ff.prog_data;
			MODE_ERASE_ONLY: cell_wdata = ERASED_BYTE;
			// Writing only clears bits; on an unerased cell the result is the AND
			MODE_WRITE_ONLY: cell_wdata = cells[cur_ff.prog_addr] & cur_ff.prog_data;
			default: cell_wdata = cells[cur_ff.prog_addr];
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic

	always_comb begin
		nxt_cur = cur_ff;
		irq_set = '0;

		// Arm window runs down by itself
		if (armed) begin
			nxt_cur.arm_cnt = 3'(cur_ff.arm_cnt - 3'h1);
		end
		if (wr_ctl && wdata_in[CTL_ARM_BIT] && !busy) begin
			nxt_cur.arm_cnt = ARM_WINDOW_CYCLES;
		end

		// Mode field frozen while programming
		if (wr_ctl && !busy) begin
			nxt_cur.mode = wdata_in[CTL_MODE_HI_BIT:CTL_MODE_LO_BIT];
		end

		// Address and data registers
		if (wr_alow) begin
			nxt_cur.addr[7:0] = wdata_in;
		end
		if (wr_ahigh) begin
			nxt_cur.addr[8] = wdata_in[0];
		end
		if (wr_data) begin
			nxt_cur.data = wdata_in;
		end

		// CPU stall countdown
		if (cur_ff.stall_cnt != 3'h0) begin
			nxt_cur.stall_cnt = 3'(cur_ff.stall_cnt - 3'h1);
		end

		// Read fetch into the data register
		if (read_go) begin
			nxt_cur.data = cells[cur_ff.addr];
			nxt_cur.stall_cnt = READ_STALL_CYCLES;
			irq_set[IRQ_READ_DONE_BIT] = 1'b1;
		end

		// Sequencer
		case (cur_ff.state)
			ST_IDLE: begin
				if (launch) begin
					nxt_cur.state = ST_PROG;
					nxt_cur.op = cur_ff.mode;
					nxt_cur.prog_addr = cur_ff.addr;
					nxt_cur.prog_data = cur_ff.data;
					nxt_cur.tick_cnt = '0;
					nxt_cur.arm_cnt = 3'h0;
					nxt_cur.stall_cnt = PROG_STALL_CYCLES;
				end
			end
			ST_PROG: begin
				if (prog_done) begin
					nxt_cur.state = ST_IDLE;
					irq_set[IRQ_PROG_DONE_BIT] = 1'b1;
				end else if (osc_tick_in) begin
					nxt_cur.tick_cnt = TICK_W'(cur_ff.tick_cnt + 16'h0001);
				end
			end
			default: begin
				nxt_cur.state = ST_IDLE;
			end
		endcase

		if (refused) begin
			irq_set[IRQ_REFUSED_BIT] = 1'b1;
		end

		// Interrupt registers; a new event wins over a clear in the same cycle
		if (wr_ien) begin
			nxt_cur.irq_enable = wdata_in[IRQ_W-1:0];
		end
		if (wr_iclr) begin
			nxt_cur.irq_status = cur_ff.irq_status & ~wdata_in[IRQ_W-1:0];
		end
		nxt_cur.irq_status = nxt_cur.irq_status | irq_set;

		// Register read, answered in the next cycle
		nxt_cur.rdata = 8'h00;
		if (rd_en_in) begin
			case (addr_in)
				OFS_CONTROL: begin
					nxt_cur.rdata[CTL_MODE_HI_BIT:CTL_MODE_LO_BIT] = cur_ff.mode;
					nxt_cur.rdata[CTL_ARM_BIT] = armed;
					nxt_cur.rdata[CTL_START_BIT] = busy;
				end
				OFS_DATA: nxt_cur.rdata = cur_ff.data;
				OFS_ADDR_LOW: nxt_cur.rdata = cur_ff.addr[7:0];
				OFS_ADDR_HIGH: nxt_cur.rdata[0] = cur_ff.addr[8];
				OFS_IRQ_STATUS: nxt_cur.rdata[IRQ_W-1:0] = cur_ff.irq_status;
				OFS_IRQ_ENABLE: nxt_cur.rdata[IRQ_W-1:0] = cur_ff.irq_enable;
				// Clear register and unmapped offsets read as zero
				default: nxt_cur.rdata = 8'h00;
			endcase
		end

		// Synchronous reset; a running programming cycle survives it
		if (!rst_n_in) begin
			nxt_cur.arm_cnt = 3'h0;
			nxt_cur.addr = '0;
			nxt_cur.data = '0;
			nxt_cur.stall_cnt = 3'h0;
			nxt_cur.irq_status = '0;
			nxt_cur.irq_enable = '0;
			nxt_cur.rdata = 8'h00;
			if (!busy) begin
				nxt_cur.mode = MODE_RESET;
				nxt_cur.state = ST_IDLE;
				nxt_cur.op = MODE_RESET;
				nxt_cur.prog_addr = '0;
				nxt_cur.prog_data = '0;
				nxt_cur.tick_cnt = '0;
			end
		end

		// Registered outputs derived from next values
		nxt_cur.stall = (nxt_cur.stall_cnt != 3'h0);
		nxt_cur.irq = |(nxt_cur.irq_status & nxt_cur.irq_enable);
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers

	// State register
	always_ff @(posedge clk_in) begin
		cur_ff <= nxt_cur;
	end

	// Cell array keeps its contents through reset, as a nonvolatile store must
	always_ff @(posedge clk_in) begin
		if (cell_we) begin
			cells[cur_ff.prog_addr] <= cell_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	always_comb begin
		rdata_out = cur_ff.rdata;
		cpu_stall_out = cur_ff.stall;
		busy_out = (cur_ff.state == ST_PROG);
		irq_out = cur_ff.irq;
	end

endmodule

/* cpu_bus_model.sv */
// Behavioural CPU side of the register port: issues one strobe at a time and never
// issues while the store holds it in a stall
module cpu_bus_model
	import nv_store_pkg::*;
(
	input wire logic clk_in,
	input wire logic stall_in,
	input wire logic [7:0] rdata_in,
	output logic [5:0] addr_out,
	output logic [7:0] wdata_out,
	output logic wr_en_out,
	output logic rd_en_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle bus from time zero
	initial {addr_out, wdata_out, wr_en_out, rd_en_out} = '0;
	////////////////////////////////////////////////////////////////////////////
	// One bus cycle; the stall is looked at after the edge has settled
	task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d,
			output logic [7:0] q);
		@(posedge clk_in);
		#1;
		while (stall_in) begin
			@(posedge clk_in);
			#1;
		end
		wr_en_out <= w;
		rd_en_out <= !w;
		addr_out <= a;
		wdata_out <= d;
		@(posedge clk_in);
		wr_en_out <= 1'b0;
		rd_en_out <= 1'b0;
		#1;
		q = rdata_in;
	endtask
	// Poll the start bit until programming is over, bounded
	task automatic wait_idle();
		logic [7:0] q;
		q = 8'h02;
		for (int i = 0; i < 300 && q[CTL_START_BIT]; i++)
			xfer(1'b0, OFS_CONTROL, 8'h00, q);
	endtask
	// Load both address halves; interrupts are never taken by this model
	task automatic set_addr(input logic [8:0] a);
		logic [7:0] q;
		xfer(1'b1, OFS_ADDR_LOW, a[7:0], q);
		xfer(1'b1, OFS_ADDR_HIGH, {7'h00, a[8]}, q);
	endtask
	// Wait, set up operands, arm with the mode, then start inside the window
	task automatic prog(input logic [1:0] m, input logic [8:0] a, input logic [7:0] d);
		logic [7:0] q;
		wait_idle();
		set_addr(a);
		xfer(1'b1, OFS_DATA, d, q);
		xfer(1'b1, OFS_CONTROL, {2'h0, m, 4'h4}, q);
		xfer(1'b1, OFS_CONTROL, {2'h0, m, 4'h2}, q);
	endtask
	// Idle check, strobe the fetch, then take the data register
	task automatic nv_read(input logic [8:0] a, output logic [7:0] q);
		wait_idle();
		set_addr(a);
		xfer(1'b1, OFS_CONTROL, 8'h01, q);
		xfer(1'b0, OFS_DATA, 8'h00, q);
	endtask
endmodule

/* nv_ctrl_properties.sv */
// Port-level checks of the store controller
module nv_ctrl_properties
	import nv_store_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [5:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	input wire logic osc_tick_in,
	input wire logic [7:0] rdata_out,
	input wire logic cpu_stall_out,
	input wire logic busy_out,
	input wire logic irq_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	logic ctl_wr;
	logic launch;
	logic [2:0] arm_ff; // Cycles left in the arm window
	logic [1:0] mode_ff; // Mode given with the arm write
	assign ctl_wr = wr_en_in && addr_in == OFS_CONTROL;
	// Reserved mode launches nothing, so it is kept out of the launch term
	assign launch = ctl_wr && wdata_in[CTL_START_BIT] && arm_ff != 3'h0 && !busy_out
		&& mode_ff != 2'h3;
	////////////////////////////////////////////////////////////////////////////
	// Shadow of the arm window seen from the bus
	always_ff @(posedge clk_in) begin
		if (!rst_n_in || launch) begin
			arm_ff <= 3'h0;
		end else if (ctl_wr && wdata_in[CTL_ARM_BIT] && !busy_out) begin
			arm_ff <= 3'h4;
			mode_ff <= wdata_in[5:4];
		end else if (arm_ff != 3'h0) begin
			arm_ff <= arm_ff - 3'h1;
		end
	end
	sequence s_rd_stall;
		cpu_stall_out [*4] ##1 !cpu_stall_out;
	endsequence
	sequence s_pg_stall;
		busy_out && cpu_stall_out ##1 cpu_stall_out ##1 !cpu_stall_out;
	endsequence
	////////////////////////////////////////////////////////////////////////////
	chk_read_stall: assert property (ctl_wr && wdata_in[0] && !busy_out |=> s_rd_stall)
		else $error("read stall not four cycles");
	chk_prog_launch: assert property (launch |=> s_pg_stall)
		else $error("launch without busy or two cycle stall");
	chk_no_launch: assert property (
		ctl_wr && wdata_in[CTL_START_BIT] && !launch && !busy_out |=> !busy_out)
		else $error("start outside arm window launched");
	chk_busy_end: assert property (
		$fell(busy_out) |-> $past(osc_tick_in, 1) || $past(osc_tick_in, 2))
		else $error("busy ended without oscillator tick");
	chk_busy_refuse: assert property (
		busy_out && $past(busy_out) && ctl_wr && wdata_in[0] |=> !cpu_stall_out)
		else $error("read accepted while busy");
	chk_rdata_idle: assert property (!rd_en_in |=> rdata_out == 8'h00)
		else $error("read data outside read answer");
	chk_unmapped_rd: assert property (
		rd_en_in && (addr_in < OFS_CONTROL || addr_in > OFS_IRQ_CLEAR) |=> rdata_out == 8'h00)
		else $error("unmapped read not zero");
	chk_ctl_read: assert property (rd_en_in && addr_in == OFS_CONTROL |=>
		rdata_out[7:6] == 2'h0 && !rdata_out[0] && rdata_out[1] == $past(busy_out))
		else $error("control read wrong");
	chk_stall_cause: assert property ($rose(cpu_stall_out) |-> $past(ctl_wr))
		else $error("stall without control write");
endmodule
bind byte_eeprom_access_controller nv_ctrl_properties chk_u (.clk_in(clk_in),
	.rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_en_in(wr_en_in),
	.rd_en_in(rd_en_in), .osc_tick_in(osc_tick_in), .rdata_out(rdata_out),
	.cpu_stall_out(cpu_stall_out), .busy_out(busy_out), .irq_out(irq_out));

/* byte_eeprom_access_controller_tb.sv */
`define CHK(a, b) begin \
	n_compared++; \
	if ((a) !== (b)) begin \
		n_mismatch++; \
		$display("[ERR] %0t got %h want %h", $time, a, b); \
	end \
end
module byte_eeprom_access_controller_tb
	import nv_store_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic osc_tick_in = 1'b0;
	logic [5:0] addr;
	logic [7:0] wdata, rdata, q;
	logic wr_en, rd_en, stall, busy, irq;
	logic [7:0] mem [NV_DEPTH]; // Expected cells, unknown until programmed
	logic [8:0] a;
	logic [1:0] m;
	int n_mismatch = 0;
	int n_compared = 0;
	int cyc = 0;
	always #4 clk_in = ~clk_in;
	// Oscillator ticks at random, about one in four cycles
	always @(posedge clk_in) osc_tick_in <= ($urandom % 4) == 0;
	// Hang guard
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 30000) begin
			n_mismatch++;
			test_done();
		end
	end
	byte_eeprom_access_controller #(.ERASE_WRITE_TICKS(16'h0008), .ERASE_ONLY_TICKS(16'h0004),
		.WRITE_ONLY_TICKS(16'h0004)) dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.addr_in(addr), .wdata_in(wdata), .wr_en_in(wr_en), .rd_en_in(rd_en),
		.osc_tick_in(osc_tick_in), .rdata_out(rdata), .cpu_stall_out(stall),
		.busy_out(busy), .irq_out(irq));
	cpu_bus_model cpu_u (.clk_in(clk_in), .stall_in(stall), .rdata_in(rdata),
		.addr_out(addr), .wdata_out(wdata), .wr_en_out(wr_en), .rd_en_out(rd_en));
	////////////////////////////////////////////////////////////////////////////
	// Cell value after an operation of the given mode
	function automatic logic [7:0] cell_after(input logic [1:0] md, input logic [7:0] old,
			input logic [7:0] d);
		case (md)
			MODE_ERASE_WRITE: return d;
			MODE_ERASE_ONLY: return ERASED_BYTE;
			default: return old & d;
		endcase
	endfunction
	task automatic do_prog(input logic [1:0] md, input logic [8:0] ad, input logic [7:0] d);
		cpu_u.prog(md, ad, d);
		mem[ad] = cell_after(md, mem[ad], d);
	endtask
	task automatic check(input logic [8:0] ad);
		cpu_u.nv_read(ad, q);
		`CHK(q, mem[ad])
	endtask
	task automatic pulse_reset();
		@(posedge clk_in);
		rst_n_in <= 1'b0;
		@(posedge clk_in);
		rst_n_in <= 1'b1;
	endtask
	task automatic test_done();
		$display("mismatches %0d compared %0d", n_mismatch, n_compared);
		if (n_mismatch == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(19));
		repeat (20) @(posedge clk_in);
		rst_n_in <= 1'b1;
		// Mapped registers and both neighbours read zero after reset
		for (int o = 30; o <= 38; o++) begin
			cpu_u.xfer(1'b0, 6'(o), 8'h00, q);
			`CHK(q, 8'h00)
		end
		// Corner addresses, then the completion interrupt
		cpu_u.xfer(1'b1, OFS_IRQ_ENABLE, 8'h01, q);
		do_prog(MODE_ERASE_WRITE, 9'h1FF, 8'hA5);
		do_prog(MODE_ERASE_WRITE, 9'h000, 8'h5A);
		check(9'h1FF);
		check(9'h000);
		`CHK(irq, 1'b1)
		cpu_u.xfer(1'b0, OFS_IRQ_STATUS, 8'h00, q);
		`CHK(q, 8'h03)
		cpu_u.xfer(1'b1, OFS_IRQ_CLEAR, 8'h07, q);
		`CHK(irq, 1'b0)
		// Write-only over an unerased cell keeps only common ones
		do_prog(MODE_WRITE_ONLY, 9'h1FF, 8'h0F);
		check(9'h1FF);
		repeat (10) begin
			a = 9'($urandom);
			m = 2'($urandom % 3);
			if (m == MODE_WRITE_ONLY) do_prog(MODE_ERASE_ONLY, a, 8'h00); // Erase first
			do_prog(m, a, 8'($urandom));
			check(a);
		end
		// Masked interrupt still records completion
		cpu_u.xfer(1'b1, OFS_IRQ_CLEAR, 8'h07, q);
		cpu_u.xfer(1'b1, OFS_IRQ_ENABLE, 8'h00, q);
		do_prog(MODE_ERASE_ONLY, 9'h010, 8'h00);
		cpu_u.wait_idle();
		`CHK(irq, 1'b0)
		cpu_u.xfer(1'b0, OFS_IRQ_STATUS, 8'h00, q);
		`CHK(q, 8'h01)
		// Start without arm, then after the window has run out
		cpu_u.xfer(1'b1, OFS_CONTROL, 8'h02, q);
		cpu_u.xfer(1'b1, OFS_CONTROL, 8'h04, q);
		cpu_u.xfer(1'b0, OFS_CONTROL, 8'h00, q);
		`CHK(q, 8'h04)
		repeat (6) @(posedge clk_in);
		cpu_u.xfer(1'b1, OFS_CONTROL, 8'h02, q);
		cpu_u.xfer(1'b0, OFS_CONTROL, 8'h00, q);
		`CHK(q, 8'h00)
		// Reserved mode 3: the window opens, but the start launches nothing
		cpu_u.xfer(1'b1, OFS_CONTROL, 8'h34, q);
		cpu_u.xfer(1'b1, OFS_CONTROL, 8'h32, q);
		cpu_u.xfer(1'b0, OFS_CONTROL, 8'h00, q);
		`CHK(q, 8'h34)
		// Mode change and fetch while busy are refused; the address low write is still taken
		do_prog(MODE_ERASE_WRITE, 9'h0AA, 8'h3C);
		cpu_u.xfer(1'b1, OFS_CONTROL, 8'h11, q);
		cpu_u.xfer(1'b1, OFS_ADDR_LOW, 8'h55, q);
		cpu_u.xfer(1'b0, OFS_DATA, 8'h00, q);
		`CHK(q, 8'h3C)
		cpu_u.xfer(1'b0, OFS_CONTROL, 8'h00, q);
		`CHK(q, 8'h02)
		check(9'h0AA);
		cpu_u.xfer(1'b0, OFS_IRQ_STATUS, 8'h00, q);
		`CHK(q[IRQ_REFUSED_BIT], 1'b1)
		// Reset while programming keeps the mode; reset when idle clears it
		do_prog(MODE_ERASE_ONLY, 9'h033, 8'h00);
		pulse_reset();
		cpu_u.xfer(1'b0, OFS_CONTROL, 8'h00, q);
		`CHK(q, 8'h12)
		check(9'h033);
		pulse_reset();
		cpu_u.xfer(1'b0, OFS_CONTROL, 8'h00, q);
		`CHK(q, 8'h00)
		test_done();
	end
endmodule
